// File: bcu_bus_cycle_unit.v
// Bus cycle unit: AHB-Lite register slave plus the sequencer that
// stretches each requester access into a timed core bus cycle.
// Assumes requester and core bus run on clk; AHB-Lite slave is sole slave.
//
// How it works
// - normal read two cycles, fast read one
// - reset selects normal reads, fast read off
// - late write two cycles, early three
// - wait cycles follow the address cycle
// - hold cycles extend the end, data kept
// - bit 0 picks early (1) or late (0)
// - wait field adds 0..7, ignored on fast
// - hold field adds 0..3, ignored on fast
// - width bit 0=8 bit, 1=16 bit, reset 16
// - post idle adds idle on zone change
// - pre idle adds idle entering new zone
// - fast enable gives one-cycle flash reads
// - io register times io zone, flash register flash
// - flash normal read adds one extra wait
`timescale 1ns/1ps
`default_nettype none
`include "bcu_defs.vh"

module bcu_bus_cycle_unit
(
  input wire clk,
  input wire reset_n,
  input wire clkEn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Requester side
  input wire reqValid,
  input wire reqWrite,
  input wire [15:0] reqAddr,
  input wire [15:0] reqWdata,
  output reg reqDone,
  output reg [15:0] reqRdata,
  // Core bus side
  input wire [15:0] busRdata,
  output reg busActive,
  output reg busWrite,
  output reg [15:0] busAddr,
  output reg [15:0] busWdata,
  output reg busWait,
  output reg busHold,
  output reg busWidth16,
  output reg [1:0] busZone
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_GAP = 3'h1;
  localparam [2:0] S_ADDR = 3'h2;
  localparam [2:0] S_WAIT = 3'h3;
  localparam [2:0] S_DATA = 3'h4;
  localparam [2:0] S_HOLD = 3'h5;

  localparam [1:0] SEL_NONE = 2'h0;
  localparam [1:0] SEL_WM = 2'h1;
  localparam [1:0] SEL_IO = 2'h2;
  localparam [1:0] SEL_FL = 2'h3;

  function [1:0] regSel;
    input [31:0] a;
    begin
      regSel = SEL_NONE;
      if (a[31:18] == 14'h0000 && a[1:0] == 2'h0)
      begin
        if (a[17:2] == `BCU_IDX_WRITE_MODE)
          regSel = SEL_WM;
        else if (a[17:2] == `BCU_IDX_IO_ZONE)
          regSel = SEL_IO;
        else if (a[17:2] == `BCU_IDX_FLASH_ZONE)
          regSel = SEL_FL;
      end
    end
  endfunction

  function [1:0] zoneOf;
    input [15:0] a;
    begin
      if (a <= `BCU_FLASH_LAST)
        zoneOf = `BCU_ZONE_FLASH;
      else if (a >= `BCU_IO_FIRST && a <= `BCU_IO_LAST)
        zoneOf = `BCU_ZONE_IO;
      else
        zoneOf = `BCU_ZONE_OTHER;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers and AHB-Lite slave

  reg [7:0] writeModeConfig;
  reg [15:0] ioZoneTimingConfig;
  reg [15:0] flashZoneTimingConfig;
  reg [1:0] dataSel;
  reg dataWrite;
  reg [7:0] next_writeModeConfig;
  reg [15:0] next_ioZoneTimingConfig;
  reg [15:0] next_flashZoneTimingConfig;
  reg [1:0] addrSel;
  reg addrTaken;

  always @*
  begin
    next_writeModeConfig = writeModeConfig;
    next_ioZoneTimingConfig = ioZoneTimingConfig;
    next_flashZoneTimingConfig = flashZoneTimingConfig;
    if (dataWrite)
    begin
      if (dataSel == SEL_WM)
        next_writeModeConfig = hwdata[7:0] & `BCU_WM_MASK;
      if (dataSel == SEL_IO)
        next_ioZoneTimingConfig = hwdata[15:0] & `BCU_IO_MASK;
      if (dataSel == SEL_FL)
        next_flashZoneTimingConfig = hwdata[15:0] & `BCU_FL_MASK;
    end
    addrTaken = hsel && htrans[1] && hready;
    addrSel = regSel(haddr);
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      // Early write and normal read after reset
      writeModeConfig <= `BCU_WM_RESET;
      ioZoneTimingConfig <= `BCU_IO_RESET;
      flashZoneTimingConfig <= `BCU_FL_RESET;
      dataSel <= SEL_NONE;
      dataWrite <= 1'b0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (clkEn)
    begin
      writeModeConfig <= next_writeModeConfig;
      ioZoneTimingConfig <= next_ioZoneTimingConfig;
      flashZoneTimingConfig <= next_flashZoneTimingConfig;
      dataSel <= addrTaken ? addrSel : SEL_NONE;
      dataWrite <= addrTaken && hwrite;
      // Read from the next values so a read right after a write sees it
      hrdata <= 32'h00000000;
      if (addrTaken && !hwrite)
      begin
        case (addrSel)
          SEL_WM: hrdata <= {24'h000000, next_writeModeConfig};
          SEL_IO: hrdata <= {16'h0000, next_ioZoneTimingConfig};
          SEL_FL: hrdata <= {16'h0000, next_flashZoneTimingConfig};
          default: hrdata <= 32'h00000000;
        endcase
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cycle budget of the pending request

  wire [1:0] reqZone;
  wire [1:0] idleCount;
  wire [1:0] baseCount;
  wire [3:0] waitCount;
  wire [1:0] holdCount;
  wire width16;
  wire postIdle;
  reg [1:0] lastZone;
  reg lastPostIdle;

  assign reqZone = zoneOf(reqAddr);

  bcu_timing_calc timing
  (
    .zone(reqZone),
    .isWrite(reqWrite),
    .writeModeConfig(writeModeConfig),
    .ioZoneTimingConfig(ioZoneTimingConfig),
    .flashZoneTimingConfig(flashZoneTimingConfig),
    .lastZone(lastZone),
    .lastPostIdle(lastPostIdle),
    .idleCount(idleCount),
    .baseCount(baseCount),
    .waitCount(waitCount),
    .holdCount(holdCount),
    .width16(width16),
    .postIdle(postIdle)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus cycle sequencer

  reg [2:0] state;
  reg [2:0] next_state;
  reg [3:0] count;
  reg [3:0] next_count;
  reg [1:0] baseLeft;
  reg [3:0] waitLeft;
  reg [1:0] holdLeft;
  reg [1:0] curZone;
  reg curPostIdle;
  reg captureRead;
  reg finish;

  // Leaves the last basic cycle toward hold or completion
  task endOfBase;
    begin
      captureRead = 1'b1;
      if (holdLeft != 2'h0)
      begin
        next_state = S_HOLD;
        next_count = {2'h0, holdLeft} - 4'h1;
      end
      else
      begin
        next_state = S_IDLE;
        finish = 1'b1;
      end
    end
  endtask

  always @*
  begin
    next_state = state;
    next_count = count;
    captureRead = 1'b0;
    finish = 1'b0;
    case (state)
      S_IDLE:
        // Done is still high the cycle after completion: no restart
        if (reqValid && !reqDone)
          next_state = (idleCount != 2'h0) ? S_GAP : S_ADDR;
      S_GAP:
        if (count == 4'h0)
          next_state = S_ADDR;
        else
          next_count = count - 4'h1;
      S_ADDR:
        if (waitLeft != 4'h0)
        begin
          next_state = S_WAIT;
          next_count = waitLeft - 4'h1;
        end
        else if (baseLeft > 2'h1)
        begin
          next_state = S_DATA;
          next_count = {2'h0, baseLeft} - 4'h2;
        end
        else
          endOfBase;
      S_WAIT:
        if (count != 4'h0)
          next_count = count - 4'h1;
        else if (baseLeft > 2'h1)
        begin
          next_state = S_DATA;
          next_count = {2'h0, baseLeft} - 4'h2;
        end
        else
          endOfBase;
      S_DATA:
        if (count != 4'h0)
          next_count = count - 4'h1;
        else
          endOfBase;
      S_HOLD:
        if (count != 4'h0)
          next_count = count - 4'h1;
        else
        begin
          next_state = S_IDLE;
          finish = 1'b1;
        end
      default:
        next_state = S_IDLE;
    endcase
    if (state == S_IDLE && next_state != S_IDLE)
      next_count = {2'h0, idleCount} - 4'h1;
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      state <= S_IDLE;
      count <= 4'h0;
      baseLeft <= 2'h0;
      waitLeft <= 4'h0;
      holdLeft <= 2'h0;
      curZone <= `BCU_ZONE_NONE;
      curPostIdle <= 1'b0;
      lastZone <= `BCU_ZONE_NONE;
      lastPostIdle <= 1'b0;
      reqDone <= 1'b0;
      reqRdata <= 16'h0000;
      busActive <= 1'b0;
      busWrite <= 1'b0;
      busAddr <= 16'h0000;
      busWdata <= 16'h0000;
      busWait <= 1'b0;
      busHold <= 1'b0;
      busWidth16 <= 1'b1;
      busZone <= `BCU_ZONE_NONE;
    end
    else if (clkEn)
    begin
      state <= next_state;
      count <= next_count;
      if (state == S_IDLE && next_state != S_IDLE)
      begin
        // Budget is frozen at the start; request must then stay put
        baseLeft <= baseCount;
        waitLeft <= waitCount;
        holdLeft <= holdCount;
        curZone <= reqZone;
        curPostIdle <= postIdle;
        busAddr <= reqAddr;
        busWrite <= reqWrite;
        busWdata <= reqWdata;
        busWidth16 <= width16;
        busZone <= reqZone;
      end
      if (finish)
      begin
        lastZone <= curZone;
        lastPostIdle <= curPostIdle;
      end
      if (captureRead && !busWrite)
        reqRdata <= busRdata;
      reqDone <= finish;
      busActive <= (next_state != S_IDLE) && (next_state != S_GAP);
      busWait <= (next_state == S_WAIT);
      busHold <= (next_state == S_HOLD);
    end
  end

endmodule

`default_nettype wire

// File: bcu_defs.vh
// Constants of the bus cycle unit: register indices, field positions,
// reset values, zone codes and basic cycle counts.
// Assumes inclusion by bare name from every design file of the block.
`ifndef BCU_DEFS_VH
`define BCU_DEFS_VH

// Register indices; the bus byte address is four times the index
`define BCU_IDX_WRITE_MODE 16'hF900
`define BCU_IDX_IO_ZONE 16'hF902
`define BCU_IDX_FLASH_ZONE 16'hF904

// Reset values and implemented-bit masks
`define BCU_WM_RESET 8'h07
`define BCU_WM_MASK 8'h07
`define BCU_IO_RESET 16'h069F
`define BCU_IO_MASK 16'h069F
`define BCU_FL_RESET 16'h069F
`define BCU_FL_MASK 16'h0EFF

// Field positions
`define BCU_EARLY_BIT 0
`define BCU_WAIT_LSB 0
`define BCU_WAIT_MSB 2
`define BCU_HOLD_LSB 3
`define BCU_HOLD_MSB 4
`define BCU_WIDTH_BIT 7
`define BCU_POST_BIT 9
`define BCU_PRE_BIT 10
`define BCU_FAST_BIT 11

// Zone codes
`define BCU_ZONE_FLASH 2'h0
`define BCU_ZONE_IO 2'h1
`define BCU_ZONE_OTHER 2'h2
`define BCU_ZONE_NONE 2'h3

// Zone address ranges
`define BCU_FLASH_LAST 16'hBFFF
`define BCU_IO_FIRST 16'hFB00
`define BCU_IO_LAST 16'hFBFF

// Basic bus cycle lengths and the flash extra wait, in clock cycles
`define BCU_FAST_READ_CYCLES 2'h1
`define BCU_NORMAL_READ_CYCLES 2'h2
`define BCU_LATE_WRITE_CYCLES 2'h2
`define BCU_EARLY_WRITE_CYCLES 2'h3
`define BCU_FLASH_EXTRA_WAIT 4'h1

`endif

// File: bcu_timing_calc.v
// Cycle budget of one access: idle, basic, wait and hold counts.
// Assumes registered configuration inputs on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "bcu_defs.vh"

module bcu_timing_calc
(
  input wire [1:0] zone,
  input wire isWrite,
  input wire [7:0] writeModeConfig,
  input wire [15:0] ioZoneTimingConfig,
  input wire [15:0] flashZoneTimingConfig,
  input wire [1:0] lastZone,
  input wire lastPostIdle,
  output reg [1:0] idleCount,
  output reg [1:0] baseCount,
  output reg [3:0] waitCount,
  output reg [1:0] holdCount,
  output reg width16,
  output reg postIdle
);

  reg [15:0] cfg;
  reg fastRead;
  reg hasCfg;
  reg newZone;

  always @*
  begin
    hasCfg = (zone == `BCU_ZONE_FLASH) || (zone == `BCU_ZONE_IO);
    cfg = (zone == `BCU_ZONE_IO) ? ioZoneTimingConfig : flashZoneTimingConfig;
    fastRead = flashZoneTimingConfig[`BCU_FAST_BIT];
    newZone = (zone != lastZone);
    if (!isWrite)
      baseCount = (fastRead && zone == `BCU_ZONE_FLASH) ?
        `BCU_FAST_READ_CYCLES : `BCU_NORMAL_READ_CYCLES;
    else
      baseCount = writeModeConfig[`BCU_EARLY_BIT] ?
        `BCU_EARLY_WRITE_CYCLES : `BCU_LATE_WRITE_CYCLES;
    waitCount = 4'h0;
    holdCount = 2'h0;
    if (hasCfg && !fastRead)
    begin
      waitCount = {1'b0, cfg[`BCU_WAIT_MSB:`BCU_WAIT_LSB]};
      holdCount = cfg[`BCU_HOLD_MSB:`BCU_HOLD_LSB];
    end
    // Flash always gets one wait except on a fast read
    if (zone == `BCU_ZONE_FLASH && !(fastRead && !isWrite))
      waitCount = waitCount + `BCU_FLASH_EXTRA_WAIT;
    width16 = hasCfg ? cfg[`BCU_WIDTH_BIT] : 1'b1;
    postIdle = hasCfg && cfg[`BCU_POST_BIT];
    // Post idle of the previous cycle and pre idle of this one add up
    idleCount = {1'b0, lastPostIdle && newZone} +
      {1'b0, hasCfg && cfg[`BCU_PRE_BIT] && newZone};
  end

endmodule

`default_nettype wire

// File: bcu_bus_cycle_unit_properties.sv
// Checker of bus cycle timing seen at the unit's ports.
// Assumes clkEn drops only while the unit is idle, and mode registers
// are written only over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module bcu_checker
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic reqDone,
  input wire logic busActive,
  input wire logic busWrite,
  input wire logic [15:0] busAddr,
  input wire logic busWait,
  input wire logic busHold,
  input wire logic [1:0] busZone
);
  logic wrPend;
  logic [31:0] wrAddr;
  logic early;
  logic fast;
  logic [3:0] waitRun;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////
  // Shadow of the mode bits, so lengths can be judged without peeking
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wrPend <= 1'b0;
      early <= 1'b1;
      fast <= 1'b0;
      waitRun <= 4'h0;
    end
    else if (clkEn)
    begin
      if (wrPend && wrAddr == 32'h0003E400)
        early <= hwdata[0];
      if (wrPend && wrAddr == 32'h0003E410)
        fast <= hwdata[11];
      wrPend <= hsel && htrans[1] && hready && hwrite;
      waitRun <= busWait ? waitRun + 4'h1 : 4'h0;
    end
  end
  always_ff @(posedge clk)
    wrAddr <= haddr;
  ////////////////////////////////////////////////////////////////////////
  property p_read_len;
    $rose(busActive) && !busWrite && busZone == 2'h2
      |-> busActive ##1 busActive ##1 (reqDone && !busActive);
  endproperty
  a_read_len: assert property (p_read_len)
    else $error("plain read length wrong");
  property p_write_len;
    $rose(busActive) && busWrite && busZone == 2'h2
      |-> ##2 (reqDone == !early) ##1 (reqDone == early);
  endproperty
  a_write_len: assert property (p_write_len)
    else $error("plain write length wrong");
  property p_fast;
    $rose(busActive) && !busWrite && busZone == 2'h0 && fast
      |=> reqDone && !busWait && !busHold;
  endproperty
  a_fast: assert property (p_fast)
    else $error("fast read not single cycle");
  property p_flash_wait;
    $rose(busActive) && !busWrite && busZone == 2'h0 && !fast |=> busWait;
  endproperty
  a_flash_wait: assert property (p_flash_wait)
    else $error("flash read lacks extra wait");
  property p_wait_pos;
    $rose(busWait) |-> $past(busActive) && !$past(busHold);
  endproperty
  a_wait_pos: assert property (p_wait_pos)
    else $error("wait not right after address");
  property p_hold_pos;
    $rose(busHold) |-> busActive && $past(busActive) && !$past(busWait);
  endproperty
  a_hold_pos: assert property (p_hold_pos)
    else $error("hold not at cycle end");
  property p_wait_max;
    busWait && !busWrite |-> waitRun < (busZone == 2'h0 ? 4'h8 : 4'h7);
  endproperty
  a_wait_max: assert property (p_wait_max)
    else $error("too many wait cycles");
  property p_hold_max;
    busHold [*3] |=> !busHold;
  endproperty
  a_hold_max: assert property (p_hold_max)
    else $error("too many hold cycles");
  property p_addr_held;
    busActive && $past(busActive) |-> $stable(busAddr) && $stable(busWrite);
  endproperty
  a_addr_held: assert property (p_addr_held)
    else $error("address moved in bus cycle");
  c_hold: cover property (busHold ##1 !busHold);
  c_early: cover property ($rose(busActive) && busWrite && early);
  c_flash: cover property (busWait && busZone == 2'h0);
endmodule
bind bcu_bus_cycle_unit bcu_checker u_chk
(
  .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .reqDone(reqDone), .busActive(busActive),
  .busWrite(busWrite), .busAddr(busAddr), .busWait(busWait),
  .busHold(busHold), .busZone(busZone)
);
`default_nettype wire

// File: bcu_core_mem.sv
// Core bus memory model answering the unit's read cycles.
// Assumes the unit holds busAddr while busActive is high.
`timescale 1ns/1ps
`default_nettype none
module bcu_core_mem
(
  input wire logic clk,
  input wire logic busActive,
  input wire logic [15:0] busAddr,
  output logic [15:0] busRdata
);
  logic [15:0] spin = 16'h1234;
  // Off-cycle data keeps changing so a late sample never looks right
  always @(posedge clk)
    spin <= spin + 16'h3C3B;
  assign busRdata = busActive ? busAddr ^ 16'hA5A5 : spin;
endmodule
`default_nettype wire

// File: bcu_bus_cycle_unit_tb.sv
// Self-checking bench of the bus cycle unit.
// Assumes the core memory model returns address xor A5A5.
`timescale 1ns/1ps
`default_nettype none
module bcu_bus_cycle_unit_tb;
  localparam logic [31:0] A_WM = 32'h0003E400;
  localparam logic [31:0] A_IO = 32'h0003E408;
  localparam logic [31:0] A_FL = 32'h0003E410;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clkEn = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [15:0] reqAddr = 16'h0;
  logic [15:0] reqWdata = 16'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic reqDone;
  logic [15:0] reqRdata;
  logic [15:0] busRdata;
  logic busActive;
  logic [15:0] busAddr;
  logic [15:0] busWdata;
  logic busWidth16;
  logic [1:0] busZone;
  logic [31:0] q;
  int n;
  int errTotal = 0;
  int numChecks = 0;
  int cyc = 0;
  bcu_bus_cycle_unit dut
  (
    .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
    .reqDone(reqDone), .reqRdata(reqRdata), .busRdata(busRdata),
    .busActive(busActive), .busWrite(), .busAddr(busAddr),
    .busWdata(busWdata), .busWait(), .busHold(),
    .busWidth16(busWidth16), .busZone(busZone)
  );
  bcu_core_mem mem
  (
    .clk(clk), .busActive(busActive), .busAddr(busAddr),
    .busRdata(busRdata)
  );
  initial
  begin
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Returns the access length in cycles counted from the taking edge
  task acc(input logic wr, input logic [15:0] a, input logic [15:0] d,
    output int len);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr <= a;
    reqWdata <= d;
    len = 0;
    do
    begin
      @(posedge clk);
      len++;
    end
    while (reqDone !== 1'b1 && len < 60);
    reqValid <= 1'b0;
    len = len - 2;
    if (wr)
      check(busWdata, d);
    else
      check(reqRdata, a ^ 16'hA5A5);
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_regs;
    check(busWidth16, 1'b1);
    check(busZone, 2'h3);
    ahb(1'b0, A_WM, 32'h0, q);
    check(q, 32'h07);
    check(hresp, 1'b0);
    ahb(1'b0, A_IO, 32'h0, q);
    check(q, 32'h069F);
    ahb(1'b0, A_FL, 32'h0, q);
    check(q, 32'h069F);
    ahb(1'b1, 32'h0003E404, 32'hFFFF, q);
    ahb(1'b0, 32'h0003E404, 32'h0, q);
    check(q, 32'h0);
  endtask
  task t_plain;
    acc(1'b0, 16'hE000, 16'h0, n);
    check(n, 2);
    acc(1'b1, 16'hE002, 16'h1234, n);
    check(n, 3);
    ahb(1'b1, A_WM, 32'h06, q);
    ahb(1'b0, A_WM, 32'h0, q);
    check(q, 32'h06);
    acc(1'b1, 16'hE004, 16'hBEEF, n);
    check(n, 2);
  endtask
  // Clock enable low: neither a register write nor a request may land
  task t_freeze;
    clkEn <= 1'b0;
    ahb(1'b1, A_WM, 32'h07, q);
    reqValid <= 1'b1;
    repeat (3) @(posedge clk);
    check(busActive, 1'b0);
    reqValid <= 1'b0;
    clkEn <= 1'b1;
    @(posedge clk);
    ahb(1'b0, A_WM, 32'h0, q);
    check(q, 32'h06);
  endtask
  task t_idle;
    acc(1'b0, 16'hFB00, 16'h0, n);
    check(n, 13);
    acc(1'b0, 16'hE000, 16'h0, n);
    check(n, 3);
  endtask
  task t_codes;
    for (int w = 0; w < 8; w++)
    begin
      ahb(1'b1, A_IO, w % 4 * 8 + w, q);
      acc(1'b0, 16'hFB02, 16'h0, n);
      check(n, 2 + w + w % 4);
    end
    check(busWidth16, 1'b0);
    check(busZone, 2'h1);
  endtask
  task t_flash;
    ahb(1'b1, A_FL, 32'h008B, q);
    acc(1'b0, 16'h0100, 16'h0, n);
    check(n, 7);
    ahb(1'b1, A_FL, 32'h088B, q);
    acc(1'b0, 16'h0102, 16'h0, n);
    check(n, 1);
    acc(1'b0, 16'hFB04, 16'h0, n);
    check(n, 2);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Whole run is well under a thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errTotal++;
      results;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_plain;
    t_freeze;
    t_idle;
    t_codes;
    t_flash;
    results;
  end
endmodule
`default_nettype wire
